/* File: hdl/osd_mode_pkg.sv */
/*
  constants for the on-screen-display mode and shadow control block:
  register offset, field positions, reset value, mode codes, shadow
  selector codes and character cell widths.
  assumes an 8-bit register port and one dot clock.
*/
// Functional notes
// R1: character ends after 12 or 14 pixels
// R2: narrow mode drops two rightmost glyph bits
// R3: mode 00 stops oscillator, black, key off
// R4: reset puts mode field at 00
// R5: mode 01 runs logic, outputs black, key off
// R6: mode 10 opaque chars over fill colour
// R7: mode 11 holds key through active line
// R8: mode 11 fill colour except foreground and shadow pixels
// R9: software passes mode 01 before active modes
// R10: 01 to active switching never disturbs logic
// R11: shadow selector decodes eight directions
// R12: shadow only on outlined rows
// R13: software writes config during vertical sync
// R14: fill colour loads only when mode nonzero
// R15: bits 6 and 3 stored, no effect
package osd_mode_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] overlay_mode_config_addr  = 8'hc1;
  localparam logic [7:0] overlay_mode_config_reset = 8'h00;
  localparam int         char_narrow_width_pos     = 7;
  localparam int         spare_hi_pos              = 6;
  localparam int         display_select_hi_pos     = 5;
  localparam int         display_select_lo_pos     = 4;
  localparam int         spare_lo_pos              = 3;
  localparam int         outline_dir_sel_2_pos     = 2;
  localparam int         outline_dir_sel_0_pos     = 0;

  // ==========================================================
  // display modes
  localparam logic [1:0] mode_disabled = 2'h0;
  localparam logic [1:0] mode_internal = 2'h1;
  localparam logic [1:0] mode_overlay  = 2'h2;
  localparam logic [1:0] mode_takeover = 2'h3;

  // ==========================================================
  // shadow directions, named by the apparent light source
  localparam logic [2:0] dir_southwest = 3'h0;
  localparam logic [2:0] dir_west      = 3'h1;
  localparam logic [2:0] dir_northwest = 3'h2;
  localparam logic [2:0] dir_north     = 3'h3;
  localparam logic [2:0] dir_northeast = 3'h4;
  localparam logic [2:0] dir_east      = 3'h5;
  localparam logic [2:0] dir_southeast = 3'h6;
  localparam logic [2:0] dir_surround  = 3'h7;

  // ==========================================================
  // character cell
  localparam int         glyph_bits     = 14;
  localparam int         narrow_pixels  = 12;
  localparam int         wide_pixels    = 14;
  localparam logic [2:0] colour_black   = 3'h0;

  typedef enum logic {px_idle, px_run} pixel_state_type;

endpackage : osd_mode_pkg

/* File: hdl/osd_mode_shadow_control.sv */
/*
  mode and shadow control for an on-screen-display character
  generator: mode register, pixel serialiser with 12/14 pixel cells,
  shadow generation and colour / overlay-key output selection.
  assumes the row fetch logic presents a glyph row with its rows above
  and below, a load pulse per character, and sync and line windows,
  all synchronous to clk, which is the dot clock.
*/
// The strobed register port was decided locally.
`timescale 1ns/1ns
module osd_mode_shadow_control
#(
  parameter int glyph_width = osd_mode_pkg::glyph_bits
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        sync_blank,
  input  wire logic        line_active,
  input  wire logic        glyph_load,
  input  wire logic [13:0] glyph_row,
  input  wire logic [13:0] glyph_row_above,
  input  wire logic [13:0] glyph_row_below,
  input  wire logic [2:0]  char_fg_colour,
  input  wire logic        char_opaque,
  input  wire logic        row_outline_enable,
  input  wire logic        fill_space_char,
  input  wire logic [2:0]  fill_colour_in,
  output logic             dot_oscillator,
  output logic             char_end,
  output logic             colour_pin_2,
  output logic             colour_pin_1,
  output logic             colour_pin_0,
  output logic             overlay_key_out
);
  import osd_mode_pkg::*;

  initial
    if (glyph_width != glyph_bits)
      $error("glyph_width must equal the glyph row width");

  // ==========================================================
  // mode register
  logic [7:0] overlay_mode_config;
  logic [1:0] display_mode;
  logic [2:0] outline_direction;
  logic       char_narrow_width;
  logic       osc_run;

  assign char_narrow_width = overlay_mode_config[char_narrow_width_pos];
  assign display_mode      = overlay_mode_config[display_select_hi_pos:
                                                 display_select_lo_pos];
  assign outline_direction = overlay_mode_config[outline_dir_sel_2_pos:
                                                 outline_dir_sel_0_pos];
  assign osc_run           = (display_mode != mode_disabled); // see R3

  // spare bits 6 and 3 are kept so software reads back what it wrote
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      overlay_mode_config <= overlay_mode_config_reset; // see R4
    else if (reg_write && reg_addr == overlay_mode_config_addr)
      overlay_mode_config <= reg_wdata; // see R15
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= (reg_read && reg_addr == overlay_mode_config_addr) ?
                   overlay_mode_config : 8'h00;
  end

  assign dot_oscillator = osc_run; // see R3

  // ==========================================================
  // fill colour, kept across fields
  logic [2:0] fill_colour;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fill_colour <= colour_black;
    else if (fill_space_char && osc_run)
      fill_colour <= fill_colour_in; // see R14
  end

  // ==========================================================
  // shadow mask: bit 13 is the leftmost pixel, so a shift right moves
  // a foreground pixel one place to the right on screen
  function automatic logic [13:0] shadow_mask
  (
    input logic [2:0]  dir,
    input logic [13:0] cur,
    input logic [13:0] above,
    input logic [13:0] below
  );
    logic [13:0] cast;
    cast = 14'h0000;
    case (dir)
      dir_southwest: cast = above >> 1;
      dir_west:      cast = cur >> 1;
      dir_northwest: cast = below >> 1;
      dir_north:     cast = below;
      dir_northeast: cast = below << 1;
      dir_east:      cast = cur << 1;
      dir_southeast: cast = above << 1;
      dir_surround:  cast = (above >> 1) | (cur >> 1) | (below >> 1) |
                            above | below |
                            (above << 1) | (cur << 1) | (below << 1);
      default:       cast = 14'h0000;
    endcase
    return cast & ~cur;
  endfunction : shadow_mask

  // narrow cells drop the two rightmost glyph bits, shadows included
  logic [13:0] width_keep;
  logic [13:0] next_fg_bits;
  logic [13:0] next_sh_bits;

  always_comb
  begin
    width_keep   = char_narrow_width ? 14'h3ffc : 14'h3fff; // see R2
    next_fg_bits = glyph_row & width_keep;
    next_sh_bits = 14'h0000;
    if (row_outline_enable) // see R12
      next_sh_bits = shadow_mask(outline_direction, next_fg_bits,
                                 glyph_row_above & width_keep,
                                 glyph_row_below & width_keep)
                     & width_keep; // see R11
  end

  // ==========================================================
  // pixel serialiser; it freezes only while the oscillator is off
  pixel_state_type pixel_state;
  logic [13:0]     fg_bits;
  logic [13:0]     sh_bits;
  logic [3:0]      pixel_count;
  logic [3:0]      last_pixel;
  logic [2:0]      cell_fg_colour;
  logic            cell_opaque;

  assign last_pixel = char_narrow_width ? 4'(narrow_pixels - 1)
                                        : 4'(wide_pixels - 1); // see R1

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pixel_state    <= px_idle;
      fg_bits        <= 14'h0000;
      sh_bits        <= 14'h0000;
      pixel_count    <= 4'h0;
      cell_fg_colour <= colour_black;
      cell_opaque    <= 1'b0;
    end
    else if (osc_run)
    begin
      if (glyph_load)
      begin
        pixel_state    <= px_run;
        fg_bits        <= next_fg_bits;
        sh_bits        <= next_sh_bits;
        pixel_count    <= 4'h0;
        cell_fg_colour <= char_fg_colour;
        cell_opaque    <= char_opaque;
      end
      else
        case (pixel_state)
          px_run:
          begin
            fg_bits     <= fg_bits << 1;
            sh_bits     <= sh_bits << 1;
            pixel_count <= pixel_count + 4'h1;
            if (pixel_count == last_pixel) // see R1
              pixel_state <= px_idle;
          end
          default:
            pixel_state <= px_idle;
        endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      char_end <= 1'b0;
    else
      char_end <= osc_run && !glyph_load && pixel_state == px_run &&
                  pixel_count == last_pixel; // see R1
  end

  // ==========================================================
  // output selection
  logic       in_cell;
  logic       pixel_fg;
  logic       pixel_sh;
  logic [2:0] next_colour;
  logic       next_key;

  assign in_cell  = (pixel_state == px_run);
  assign pixel_fg = in_cell && fg_bits[13];
  assign pixel_sh = in_cell && sh_bits[13];

  always_comb
  begin
    next_colour = colour_black;
    next_key    = 1'b0;
    case (display_mode)
      mode_disabled, mode_internal:
        next_colour = colour_black; // see R3, R5
      mode_overlay:
      begin
        if (pixel_fg)
        begin
          next_colour = cell_fg_colour;
          next_key    = 1'b1;
        end
        else if (pixel_sh)
          next_key = 1'b1; // shadow pixels stay black
        else if (in_cell && cell_opaque)
        begin
          next_colour = fill_colour; // see R6
          next_key    = 1'b1;
        end
      end
      mode_takeover:
      begin
        next_key = line_active; // see R7
        if (pixel_fg)
          next_colour = cell_fg_colour;
        else if (pixel_sh)
          next_colour = colour_black;
        else if (line_active)
          next_colour = fill_colour; // see R8
      end
      default:
        next_key = 1'b0;
    endcase
    // sync intervals always show black with the key off
    if (sync_blank)
    begin
      next_colour = colour_black;
      next_key    = 1'b0;
    end
  end

  // mode 01 <-> 10/11 changes only this mux, never the serialiser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      colour_pin_2    <= 1'b0;
      colour_pin_1    <= 1'b0;
      colour_pin_0    <= 1'b0;
      overlay_key_out <= 1'b0;
    end
    else
    begin
      colour_pin_2    <= next_colour[2]; // see R10
      colour_pin_1    <= next_colour[1];
      colour_pin_0    <= next_colour[0];
      overlay_key_out <= next_key;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // clean cycles since a cell load: no write, no reload, oscillator on;
  // a counter keeps the 12 pixel check from unrolling a long repetition
  logic [3:0] cell_age;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cell_age <= 4'hf;
    else if (!osc_run || reg_write)
      cell_age <= 4'hf;
    else if (glyph_load)
      cell_age <= 4'h0;
    else if (cell_age != 4'hf)
      cell_age <= cell_age + 4'h1;
  end

  a_quiet_modes_black: assert property ( // see R3
    !display_mode[1] |=> !overlay_key_out && !colour_pin_2 &&
                         !colour_pin_1 && !colour_pin_0)
    else $error("low modes must show black with the key off");
  a_osc_follows_mode: assert property ( // see R5
    (reg_write && reg_addr == overlay_mode_config_addr) |=>
    dot_oscillator == ($past(reg_wdata[5:4]) != mode_disabled))
    else $error("oscillator does not follow the mode field");
  a_narrow_cell_end: assert property ( // see R1
    (cell_age == 4'hc && char_narrow_width) |-> char_end && !$past(char_end))
    else $error("narrow cell did not end after 12 pixels");
  a_wide_cell_run: assert property ( // see R1
    (osc_run && glyph_load && !char_narrow_width) ##1
    (osc_run && !glyph_load && !$changed(overlay_mode_config)) [*8]
    |-> in_cell && !char_end)
    else $error("wide cell ended early");
  a_narrow_drop_bits: assert property ( // see R2
    (osc_run && glyph_load && char_narrow_width) |=>
    fg_bits[1:0] == 2'h0 && sh_bits[1:0] == 2'h0)
    else $error("narrow cell kept its rightmost glyph bits");
  a_takeover_key: assert property ( // see R7
    (display_mode == mode_takeover && line_active && !sync_blank)
    |=> overlay_key_out)
    else $error("key not held through the active line");
  a_fill_hold_off: assert property ( // see R14
    (display_mode == mode_disabled) |=> $stable(fill_colour))
    else $error("fill colour changed in the disabled mode");
  a_fill_load: assert property ( // see R14
    (fill_space_char && osc_run) |=> fill_colour == $past(fill_colour_in))
    else $error("fill colour not taken");
  a_no_outline_row: assert property ( // see R12
    (osc_run && glyph_load && !row_outline_enable) |=> sh_bits == 14'h0000)
    else $error("shadow on a row without outline");
  a_opaque_fill: assert property ( // see R6
    (display_mode == mode_overlay && in_cell && cell_opaque &&
     !pixel_fg && !pixel_sh && !sync_blank)
    |=> overlay_key_out &&
        {colour_pin_2, colour_pin_1, colour_pin_0} == $past(fill_colour))
    else $error("opaque background not shown in fill colour");
  a_takeover_fill: assert property ( // see R8
    (display_mode == mode_takeover && line_active && !pixel_fg &&
     !pixel_sh && !sync_blank)
    |=> {colour_pin_2, colour_pin_1, colour_pin_0} == $past(fill_colour))
    else $error("takeover background not the fill colour");

endmodule : osd_mode_shadow_control

/* File: verif/tv_video_mixer.sv */
/*
  behavioural model of the receiver video switch beyond the block's
  colour and overlay-key pins: it makes a moving picture of its own and
  shows either that or the on-screen colour.
  assumes internal colour polarity and an active-high key.
*/
`timescale 1ns/1ns
module tv_video_mixer
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       colour_pin_2,
  input  wire logic       colour_pin_1,
  input  wire logic       colour_pin_0,
  input  wire logic       overlay_key_out,
  output logic      [2:0] tv_picture,
  output logic      [2:0] screen
);
  // picture changes every dot so a stuck key cannot pass for a match
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tv_picture <= 3'h0;
    else
      tv_picture <= tv_picture + 3'h3;
  end

  // key high shows the osd colour, low the receiver's own video
  assign screen = overlay_key_out ?
    {colour_pin_2, colour_pin_1, colour_pin_0} : tv_picture;
endmodule : tv_video_mixer

/* File: verif/test_osd_mode_shadow_control.sv */
/*
  self-checking bench for the mode and shadow control block: register
  port, pixel stream in every mode, shadow directions.
  assumes the video mixer model and the design package.
*/
`timescale 1ns/1ns
module test_osd_mode_shadow_control;
  import osd_mode_pkg::*;
  logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, sync_blank = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cfg = 8'h00;
  logic line_active = 1, glyph_load = 0, char_opaque = 0;
  logic row_outline_enable = 0, fill_space_char = 0, opq = 0, outl = 0;
  logic [13:0] glyph_row = 0, glyph_row_above = 0, glyph_row_below = 0;
  logic [13:0] g_cur = 0, g_up = 0, g_dn = 0;
  logic [2:0] char_fg_colour = 0, fill_colour_in = 0, fg = 0, fill = 0;
  logic sb = 0;
  wire logic [7:0] reg_rdata;
  wire logic dot_oscillator, char_end, overlay_key_out;
  wire logic colour_pin_2, colour_pin_1, colour_pin_0;
  wire logic [2:0] tv_picture, screen;
  wire logic [2:0] pins = {colour_pin_2, colour_pin_1, colour_pin_0};
  int failures = 0, n_checks = 0, cycles = 0, i, d;

  always #25 clk = ~clk;

  osd_mode_shadow_control dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sync_blank(sync_blank),
    .line_active(line_active), .glyph_load(glyph_load),
    .glyph_row(glyph_row), .glyph_row_above(glyph_row_above),
    .glyph_row_below(glyph_row_below), .char_fg_colour(char_fg_colour),
    .char_opaque(char_opaque), .row_outline_enable(row_outline_enable),
    .fill_space_char(fill_space_char), .fill_colour_in(fill_colour_in),
    .dot_oscillator(dot_oscillator), .char_end(char_end),
    .colour_pin_2(colour_pin_2), .colour_pin_1(colour_pin_1),
    .colour_pin_0(colour_pin_0), .overlay_key_out(overlay_key_out));
  tv_video_mixer mix_u (.clk(clk), .rst(rst), .colour_pin_2(colour_pin_2),
    .colour_pin_1(colour_pin_1), .colour_pin_0(colour_pin_0),
    .overlay_key_out(overlay_key_out), .tv_picture(tv_picture),
    .screen(screen));

  // ==========================================================
  // compare tasks and verdict
  task automatic chk1(input logic a, input logic e, input string m);
    n_checks++;
    if (a !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %b want %b", $time, m, a, e);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] a, input logic [7:0] e,
                      input string m);
    n_checks++;
    if (a !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, m, a, e);
    end
  endtask : chk8
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop;
    end
  end

  // ==========================================================
  // register port and stimulus helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sync_blank <= 1'b1;
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
    sync_blank <= sb;
    if (a == overlay_mode_config_addr)
      cfg = v;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk8(reg_rdata, e, "read data");
  endtask : rd
  task automatic set_cfg(input logic [7:0] v);
    if (cfg[5:4] == mode_disabled && v[5])
      wr(overlay_mode_config_addr, {v[7:6], mode_internal, v[3:0]});
    wr(overlay_mode_config_addr, v);
  endtask : set_cfg
  task automatic load_fill(input logic [2:0] c);
    @(posedge clk);
    fill_space_char <= 1'b1;
    fill_colour_in <= c;
    @(posedge clk);
    fill_space_char <= 1'b0;
    if (cfg[5:4] != mode_disabled)
      fill = c;
  endtask : load_fill

  // expected {key, colour} of pixel j of the cell now loaded
  function automatic logic [3:0] exp_px(input int j);
    logic [13:0] mk;
    logic [15:0] c, u, n;
    logic s;
    int b;
    mk = cfg[7] ? 14'h3ffc : 14'h3fff;
    c = {1'b0, g_cur & mk, 1'b0};
    u = {1'b0, g_up & mk, 1'b0};
    n = {1'b0, g_dn & mk, 1'b0};
    b = 14 - j;
    if (sb || cfg[5:4] < 2'h2)
      return 4'h0;
    if (j >= (cfg[7] ? narrow_pixels : wide_pixels))
      return (cfg[5:4] == mode_takeover) ? {line_active, fill} : 4'h0;
    case (cfg[2:0])
      dir_southwest: s = u[b+1];
      dir_west:      s = c[b+1];
      dir_northwest: s = n[b+1];
      dir_north:     s = n[b];
      dir_northeast: s = n[b-1];
      dir_east:      s = c[b-1];
      dir_southeast: s = u[b-1];
      default: s = |{u[b+1], u[b], u[b-1], c[b+1], c[b-1],
                     n[b+1], n[b], n[b-1]};
    endcase
    if (c[b])
      return {1'b1, fg};
    if (s && outl)
      return 4'h8;
    if (cfg[5:4] == mode_takeover)
      return {1'b1, fill};
    return {opq, opq ? fill : 3'h0};
  endfunction : exp_px

  task automatic run_cell;
    logic [3:0] e;
    int j;
    @(posedge clk);
    glyph_load <= 1'b1;
    glyph_row <= g_cur;
    glyph_row_above <= g_up;
    glyph_row_below <= g_dn;
    char_fg_colour <= fg;
    char_opaque <= opq;
    row_outline_enable <= outl;
    @(posedge clk);
    glyph_load <= 1'b0;
    for (j = 0; j < 16; j++)
    begin
      @(posedge clk);
      @(negedge clk);
      e = exp_px(j);
      chk1(overlay_key_out, e[3], "key");
      if (e[3] || sb || cfg[5:4] < 2'h2)
        chk8({5'h0, pins}, {5'h0, e[2:0]}, "colour");
      chk8({5'h0, screen}, {5'h0, e[3] ? e[2:0] : tv_picture}, "mix");
      chk1(char_end, cfg[5:4] != mode_disabled &&
           j + 1 == (cfg[7] ? narrow_pixels : wide_pixels), "end");
    end
  endtask : run_cell

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h17a8));
    repeat (12) @(posedge clk);
    chk8({4'h0, pins, overlay_key_out}, 8'h00, "reset pins");
    rst <= 1'b0;
    rd(overlay_mode_config_addr, overlay_mode_config_reset);
    chk1(dot_oscillator, 1'b0, "osc off");
    load_fill(3'h5);
    g_cur = 14'h3fff;
    fg = 3'h6;
    run_cell;
    for (i = 0; i < 6; i++)
    begin
      d = ($urandom & 8'hcf) | 8'h10;
      wr(overlay_mode_config_addr, 8'(d));
      wr(8'(overlay_mode_config_addr + 1 + i), 8'hff);
      rd(overlay_mode_config_addr, 8'(d));
      rd(8'(overlay_mode_config_addr - 1 - i), 8'h00);
    end
    chk1(dot_oscillator, 1'b1, "osc on");
    outl = 1;
    run_cell;
    load_fill(3'($urandom));
    for (i = 0; i < 40; i++)
    begin
      g_cur = 14'($urandom);
      g_up = 14'($urandom);
      g_dn = 14'($urandom);
      fg = 3'($urandom);
      opq = 1'($urandom);
      outl = 1'($urandom);
      if (i % 4 == 0)
        load_fill(3'($urandom));
      set_cfg({1'($urandom), 2'h1, 1'($urandom), 1'b0, 3'($urandom)});
      run_cell;
      if (i % 5 == 0)
      begin
        set_cfg({cfg[7:6], mode_internal, cfg[3:0]});
        run_cell;
      end
    end
    {g_up, g_cur, g_dn, opq} = {14'h0400, 14'h0080, 14'h0010, 1'b0};
    for (d = 0; d < 16; d++)
    begin
      outl = d < 8;
      set_cfg({5'h04, 3'(d)});
      run_cell;
    end
    g_cur = 14'h3fff;
    set_cfg({1'b1, 1'b0, mode_overlay, 4'h0});
    run_cell;
    sb = 1;
    set_cfg({2'h0, mode_takeover, 4'h0});
    run_cell;
    sb = 0;
    @(posedge clk);
    sync_blank <= 1'b0;
    line_active <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk1(overlay_key_out, 1'b0, "key outside line");
    @(posedge clk);
    line_active <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk1(overlay_key_out, 1'b1, "key in line");
    report_and_stop;
  end
endmodule : test_osd_mode_shadow_control
